// ### sod_defines.vh
// object indices, field positions, reset values and mode codes of the servo object dictionary
`ifndef SOD_DEFINES_VH
`define SOD_DEFINES_VH

// object indices used on the object access port
`define SOD_IDX_LATEST_ERROR_CODE 16'h603f
`define SOD_IDX_DRIVE_STATE_WORD 16'h6041
`define SOD_IDX_ACTUAL_POSITION 16'h6064
`define SOD_IDX_VELOCITY_CEILING 16'h607f
`define SOD_IDX_PROBE_CONFIGURATION 16'h60b8

// reset values
`define SOD_RST_VELOCITY_CEILING 32'h06400000
`define SOD_RST_PROBE_CONFIGURATION 16'h0000
`define SOD_RST_LATEST_ERROR_CODE 16'h0000

// probe configuration fields, offset within the byte of each probe
`define SOD_PRB_STRIDE 8
`define SOD_PRB_ENABLE 0
`define SOD_PRB_CONTINUOUS 1
`define SOD_PRB_SOURCE 2
`define SOD_PRB_RISE_EN 4
`define SOD_PRB_FALL_EN 5

// drive state word bit positions
`define SOD_SW_READY 0
`define SOD_SW_SERVO_ON_CMD 1
`define SOD_SW_OP_ENABLED 2
`define SOD_SW_FAULT 3
`define SOD_SW_VOLTAGE 4
`define SOD_SW_QUICK_STOP_N 5
`define SOD_SW_SWITCH_ON_DIS 6
`define SOD_SW_ALARM 7
`define SOD_SW_REMOTE 9
`define SOD_SW_TARGET_REACHED 10
`define SOD_SW_INTERNAL_LIMIT 11
`define SOD_SW_MODE_LO 12
`define SOD_SW_MODE_HI 13
`define SOD_SW_HOMING_DONE 15

// error code field width
`define SOD_ERR_CODE_W 12

// operating mode codes
`define SOD_MODE_PROFILE_VELOCITY 8'h03
`define SOD_MODE_PROFILE_TORQUE 8'h04
`define SOD_MODE_CYCLIC_SYNC_POSITION 8'h08
`define SOD_MODE_SPEED_TORQUE 8'hfc

`endif

// ### sod_core.v
// servo object dictionary slice: velocity ceiling, touch probes, state word, position, error code
`timescale 1ns/10ps
`include "sod_defines.vh"

module sod_core (
   // clock and reset
   input wire clk,
   input wire srst,
   // object access port
   input wire obj_rd,
   input wire obj_wr,
   input wire [15:0] obj_index,
   input wire [31:0] obj_wdata,
   output reg [31:0] obj_rdata,
   output reg obj_ack,
   output reg obj_err,
   // speed path
   input wire [7:0] op_mode,
   input wire [31:0] speed_request,
   output reg [31:0] speed_command,
   output reg speed_limited,
   // position path
   input wire [31:0] position_target,
   input wire [31:0] software_limit,
   input wire limit_hit,
   output reg [31:0] effective_target,
   input wire [31:0] user_position,
   input wire [31:0] position_factor,
   output reg [31:0] pulse_position,
   // probe inputs and index
   input wire probe_one_input,
   input wire probe_two_input,
   input wire encoder_index,
   input wire absolute_encoder,
   input wire [23:0] single_turn_position,
   // probe results
   output reg [31:0] probe_one_rise_position,
   output reg [31:0] probe_one_fall_position,
   output reg [31:0] probe_two_rise_position,
   output reg [31:0] probe_two_fall_position,
   output reg [3:0] probe_latched,
   // drive state inputs
   input wire drive_ready,
   input wire servo_on_cmd,
   input wire operation_enabled,
   input wire fault,
   input wire voltage_enabled,
   input wire quick_stop_active,
   input wire switch_on_disabled,
   input wire alarm,
   input wire target_reached,
   input wire homing_done,
   input wire [1:0] mode_specific,
   // error reporting
   input wire error_event,
   input wire [11:0] error_code_in
);

   // dictionary storage
   reg [31:0] velocity_ceiling;
   reg [15:0] probe_configuration;
   reg [15:0] drive_state_word;
   reg [31:0] actual_position;
   reg [15:0] latest_error_code;

   // probe state, index 0 is probe one
   reg [31:0] cap_rise [0:1];
   reg [31:0] cap_fall [0:1];
   reg [1:0] got_rise;
   reg [1:0] got_fall;
   reg [1:0] armed;
   reg [1:0] src_prev;
   reg [1:0] en_prev;
   reg index_prev;
   wire [1:0] probe_pin;
   wire index_level;

   // speed clamp helpers
   wire limit_mode;
   wire signed [33:0] req_ext;
   wire signed [33:0] ceil_pos;
   wire signed [33:0] ceil_neg;
   reg [31:0] next_speed;
   reg next_limited;
   wire [63:0] pulse_product;

   assign probe_pin = {probe_two_input, probe_one_input};

   // absolute encoders have no index track, so zero of the single turn stands in for it
   assign index_level = absolute_encoder ? (single_turn_position == 24'h000000) :
                        encoder_index;

   // ---------------------------------------------------------------
   // object access: reads and writes answer one cycle after the strobe
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         velocity_ceiling <= `SOD_RST_VELOCITY_CEILING;
         probe_configuration <= `SOD_RST_PROBE_CONFIGURATION;
         obj_rdata <= 32'h00000000;
         obj_ack <= 1'b0;
         obj_err <= 1'b0;
      end else begin
         obj_ack <= obj_rd | obj_wr;
         obj_err <= 1'b0;
         if (obj_wr) begin
            case (obj_index)
               `SOD_IDX_VELOCITY_CEILING: begin
                  velocity_ceiling <= obj_wdata;
               end
               `SOD_IDX_PROBE_CONFIGURATION: begin
                  probe_configuration <= obj_wdata[15:0];
               end
               // read-only objects refuse writes, as do unknown indices
               default: begin
                  obj_err <= 1'b1;
               end
            endcase
         end else if (obj_rd) begin
            case (obj_index)
               `SOD_IDX_LATEST_ERROR_CODE: begin
                  obj_rdata <= {16'h0000, latest_error_code};
               end
               `SOD_IDX_DRIVE_STATE_WORD: begin
                  obj_rdata <= {16'h0000, drive_state_word};
               end
               `SOD_IDX_ACTUAL_POSITION: begin
                  obj_rdata <= actual_position;
               end
               `SOD_IDX_VELOCITY_CEILING: begin
                  obj_rdata <= velocity_ceiling;
               end
               `SOD_IDX_PROBE_CONFIGURATION: begin
                  obj_rdata <= {16'h0000, probe_configuration};
               end
               default: begin
                  obj_rdata <= 32'h00000000;
                  obj_err <= 1'b1;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // speed ceiling
   // ---------------------------------------------------------------
   // cyclic synchronous position and all other modes pass the request untouched
   assign limit_mode = (op_mode == `SOD_MODE_PROFILE_VELOCITY) ||
                       (op_mode == `SOD_MODE_PROFILE_TORQUE) ||
                       (op_mode == `SOD_MODE_SPEED_TORQUE);
   assign req_ext = {{2{speed_request[31]}}, speed_request};
   // two extra bits so a ceiling above the signed range never wraps negative
   assign ceil_pos = {2'b00, velocity_ceiling};
   assign ceil_neg = -ceil_pos;

   always @* begin
      next_speed = speed_request;
      next_limited = 1'b0;
      if (limit_mode) begin
         // torque loop may accelerate the motor, but only up to the ceiling
         if (req_ext > ceil_pos) begin
            next_speed = velocity_ceiling;
            next_limited = 1'b1;
         end else if (req_ext < ceil_neg) begin
            next_speed = ceil_neg[31:0];
            next_limited = 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         speed_command <= 32'h00000000;
         speed_limited <= 1'b0;
      end else begin
         speed_command <= next_speed;
         speed_limited <= next_limited;
      end
   end

   // ---------------------------------------------------------------
   // position, limit target and gear factor
   // ---------------------------------------------------------------
   // low word only: a factor that overflows 32 bits wraps, as the pulse counter would
   assign pulse_product = user_position * position_factor;

   always @(posedge clk) begin
      if (srst) begin
         actual_position <= 32'h00000000;
         pulse_position <= 32'h00000000;
         effective_target <= 32'h00000000;
      end else begin
         actual_position <= user_position;
         pulse_position <= pulse_product[31:0];
         effective_target <= limit_hit ? software_limit : position_target;
      end
   end

   // ---------------------------------------------------------------
   // drive state word and latest error
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         drive_state_word <= 16'h0000;
         latest_error_code <= `SOD_RST_LATEST_ERROR_CODE;
      end else begin
         // each bit except the fixed bits 8, 9 and 14 mirrors the acknowledged state of the drive sequencer
         drive_state_word[`SOD_SW_READY] <= drive_ready;
         drive_state_word[`SOD_SW_SERVO_ON_CMD] <= servo_on_cmd;
         drive_state_word[`SOD_SW_OP_ENABLED] <= operation_enabled;
         drive_state_word[`SOD_SW_FAULT] <= fault;
         drive_state_word[`SOD_SW_VOLTAGE] <= voltage_enabled;
         drive_state_word[`SOD_SW_QUICK_STOP_N] <= ~quick_stop_active;
         drive_state_word[`SOD_SW_SWITCH_ON_DIS] <= switch_on_disabled;
         drive_state_word[`SOD_SW_ALARM] <= alarm;
         drive_state_word[8] <= 1'b0;
         drive_state_word[`SOD_SW_REMOTE] <= 1'b1;
         drive_state_word[`SOD_SW_TARGET_REACHED] <= target_reached;
         drive_state_word[`SOD_SW_INTERNAL_LIMIT] <= limit_hit;
         drive_state_word[`SOD_SW_MODE_LO] <= mode_specific[0];
         drive_state_word[`SOD_SW_MODE_HI] <= mode_specific[1];
         drive_state_word[14] <= 1'b0;
         drive_state_word[`SOD_SW_HOMING_DONE] <= homing_done;
         if (error_event) begin
            latest_error_code <= {4'h0, error_code_in};
         end
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         index_prev <= 1'b0;
      end else begin
         index_prev <= index_level;
      end
   end

   // ---------------------------------------------------------------
   // touch probes, one instance of the same logic per probe
   // ---------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_probe
         wire en;
         wire cont;
         wire src;
         wire rise_en;
         wire fall_en;
         wire sel;
         wire sel_prev;
         wire rise_ok;
         wire fall_ok;
         assign en = probe_configuration[p * `SOD_PRB_STRIDE + `SOD_PRB_ENABLE];
         assign cont = probe_configuration[p * `SOD_PRB_STRIDE + `SOD_PRB_CONTINUOUS];
         assign src = probe_configuration[p * `SOD_PRB_STRIDE + `SOD_PRB_SOURCE];
         assign rise_en = probe_configuration[p * `SOD_PRB_STRIDE + `SOD_PRB_RISE_EN];
         assign fall_en = probe_configuration[p * `SOD_PRB_STRIDE + `SOD_PRB_FALL_EN];
         assign sel = src ? index_level : probe_pin[p];
         // previous level follows the same source choice so a switch does not fake an edge
         assign sel_prev = src ? index_prev : src_prev[p];
         // the index track has no usable rising edge for latching
         assign rise_ok = en & armed[p] & rise_en & ~src & sel & ~sel_prev;
         assign fall_ok = en & armed[p] & fall_en & ~sel & sel_prev;

         always @(posedge clk) begin
            if (srst) begin
               cap_rise[p] <= 32'h00000000;
               cap_fall[p] <= 32'h00000000;
               got_rise[p] <= 1'b0;
               got_fall[p] <= 1'b0;
               armed[p] <= 1'b0;
               src_prev[p] <= 1'b0;
               en_prev[p] <= 1'b0;
            end else begin
               src_prev[p] <= probe_pin[p];
               en_prev[p] <= en;
               if (!en) begin
                  // disabling clears the flags; captured values stay readable
                  got_rise[p] <= 1'b0;
                  got_fall[p] <= 1'b0;
                  armed[p] <= 1'b0;
               end else begin
                  if (!en_prev[p]) begin
                     armed[p] <= 1'b1;
                  end else if ((rise_ok | fall_ok) & ~cont) begin
                     armed[p] <= 1'b0;
                  end
                  if (rise_ok) begin
                     cap_rise[p] <= user_position;
                     got_rise[p] <= 1'b1;
                  end
                  if (fall_ok) begin
                     cap_fall[p] <= user_position;
                     got_fall[p] <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // register the result ports so the master never sees a half-updated capture
   always @(posedge clk) begin
      if (srst) begin
         probe_one_rise_position <= 32'h00000000;
         probe_one_fall_position <= 32'h00000000;
         probe_two_rise_position <= 32'h00000000;
         probe_two_fall_position <= 32'h00000000;
         probe_latched <= 4'h0;
      end else begin
         probe_one_rise_position <= cap_rise[0];
         probe_one_fall_position <= cap_fall[0];
         probe_two_rise_position <= cap_rise[1];
         probe_two_fall_position <= cap_fall[1];
         probe_latched <= {got_fall[1], got_rise[1], got_fall[0], got_rise[0]};
      end
   end

endmodule // sod_core

// ### sod_core_checker.sv
// concurrent checks on the ports of the servo object dictionary core
`timescale 1ns/10ps
module sod_core_checker (
   // clock and reset
   input wire clk,
   input wire srst,
   // object port
   input wire obj_rd,
   input wire obj_wr,
   input wire [15:0] obj_index,
   input wire obj_ack,
   input wire obj_err,
   // speed and position
   input wire [7:0] op_mode,
   input wire [31:0] speed_request,
   input wire [31:0] speed_command,
   input wire speed_limited,
   input wire limit_hit,
   input wire [31:0] software_limit,
   input wire [31:0] position_target,
   input wire [31:0] effective_target,
   // probes
   input wire probe_one_input,
   input wire [3:0] probe_latched
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_lone_req;
      (obj_rd || obj_wr) ##1 !(obj_rd || obj_wr);
   endsequence
   sequence s_answer;
      obj_ack ##1 !obj_ack;
   endsequence
   ack_once_a: assert property (s_lone_req |-> s_answer)
      else $error("access not answered by one ack");
   idle_ack_a: assert property (!(obj_rd || obj_wr) |=> !obj_ack)
      else $error("ack without access");
   err_ack_a: assert property (obj_err |-> obj_ack)
      else $error("error flag outside ack");
   ro_write_a: assert property (obj_wr && (obj_index == 16'h603f ||
      obj_index == 16'h6041 || obj_index == 16'h6064) |=> obj_err)
      else $error("write to read-only object accepted");
   ceiling_read_a: assert property (obj_rd && !obj_wr && obj_index == 16'h607f |=> !obj_err)
      else $error("ceiling read refused");
   csp_pass_a: assert property (op_mode == 8'h08 |=> !speed_limited &&
      speed_command == $past(speed_request))
      else $error("speed altered in position mode");
   clamp_flag_a: assert property (speed_limited |-> speed_command != $past(speed_request))
      else $error("limited flag without clamping");
   limit_target_a: assert property (limit_hit |=> effective_target == $past(software_limit))
      else $error("limit not taken as target");
   free_target_a: assert property (!limit_hit |=> effective_target == $past(position_target))
      else $error("target not passed through");
   rise_cause_a: assert property ($rose(probe_latched[0]) |->
      $past(probe_one_input, 2) || $past(probe_one_input, 3))
      else $error("rise latched without high pin");
   reset_clear_a: assert property (disable iff (1'b0) srst |=> !obj_ack &&
      probe_latched == 4'h0 && speed_command == 32'h0)
      else $error("outputs not cleared by reset");
endmodule // sod_core_checker

// ### sod_master.sv
// motion master model: issues single object accesses on the object port
`timescale 1ns/10ps
module sod_master (
   // clock
   input wire clk,
   // object port
   output reg obj_rd,
   output reg obj_wr,
   output reg [15:0] obj_index,
   output reg [31:0] obj_wdata,
   input wire [31:0] obj_rdata,
   input wire obj_ack,
   input wire obj_err
);
   initial begin
      obj_rd = 1'b0;
      obj_wr = 1'b0;
      obj_index = 16'h0;
      obj_wdata = 32'h0;
   end
   // one-cycle strobe, the answer is taken while ack stands
   task access(input wr, input [15:0] idx, input [31:0] wd, output [31:0] rd,
      output [1:0] st);
      begin
         @(posedge clk);
         #1;
         obj_wr = wr;
         obj_rd = !wr;
         obj_index = idx;
         obj_wdata = wd;
         @(posedge clk);
         #1;
         obj_wr = 1'b0;
         obj_rd = 1'b0;
         // released lines change so a stale value is never trusted
         obj_index = ~idx;
         obj_wdata = ~wd;
         rd = obj_rdata;
         st = {obj_ack, obj_err};
      end
   endtask
endmodule // sod_master

// ### sod_core_test.sv
// self-checking bench for the servo object dictionary core
`timescale 1ns/10ps
module sod_core_test;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg [7:0] op_mode = 8'h0;
   reg [31:0] speed_request = 32'h0, position_target = 32'h0, software_limit = 32'h0;
   reg [31:0] user_position = 32'h0, position_factor = 32'h0, seed = 32'h6c63, v, c, rd;
   reg p1 = 1'b0, p2 = 1'b0, enc_idx = 1'b0, abs_enc = 1'b0, err_ev = 1'b0;
   reg [23:0] turn = 24'h1;
   reg [11:0] code = 12'h0;
   reg [12:0] st = 13'h0;
   reg [1:0] ae;
   reg [39:0] mode_tab = 40'h030_4fc_0801;
   wire [31:0] obj_rdata, obj_wdata, speed_command, effective_target, pulse_position;
   wire [31:0] p1r, p1f, p2r, p2f;
   wire [15:0] obj_index;
   wire [3:0] probe_latched;
   wire obj_rd, obj_wr, obj_ack, obj_err, speed_limited;
   integer err_count = 0, n_tests = 0, i;
   sod_core u_sod_core (.clk(clk), .srst(srst), .obj_rd(obj_rd), .obj_wr(obj_wr),
      .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
      .obj_err(obj_err), .op_mode(op_mode), .speed_request(speed_request),
      .speed_command(speed_command), .speed_limited(speed_limited),
      .position_target(position_target), .software_limit(software_limit),
      .limit_hit(st[12]), .effective_target(effective_target), .user_position(user_position),
      .position_factor(position_factor), .pulse_position(pulse_position),
      .probe_one_input(p1), .probe_two_input(p2), .encoder_index(enc_idx),
      .absolute_encoder(abs_enc), .single_turn_position(turn), .probe_one_rise_position(p1r),
      .probe_one_fall_position(p1f), .probe_two_rise_position(p2r),
      .probe_two_fall_position(p2f), .probe_latched(probe_latched), .drive_ready(st[0]),
      .servo_on_cmd(st[1]), .operation_enabled(st[2]), .fault(st[3]),
      .voltage_enabled(st[4]), .quick_stop_active(st[5]), .switch_on_disabled(st[6]),
      .alarm(st[7]), .target_reached(st[8]), .homing_done(st[9]),
      .mode_specific(st[11:10]), .error_event(err_ev), .error_code_in(code));
   sod_master u_sod_master (.clk(clk), .obj_rd(obj_rd), .obj_wr(obj_wr),
      .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
      .obj_ack(obj_ack), .obj_err(obj_err));
   initial begin
      forever #5 clk = ~clk;
   end
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task acc(input wr, input [15:0] idx, input [31:0] wd);
      u_sod_master.access(wr, idx, wd, rd, ae);
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   function [31:0] rnd();
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   function [31:0] clamp(input [7:0] m, input [31:0] r, input [31:0] cl);
      begin
         clamp = r;
         if (m == 8'h03 || m == 8'h04 || m == 8'hfc) begin
            if ($signed(r) > $signed(cl)) clamp = cl;
            if ($signed(r) < -$signed(cl)) clamp = -cl;
         end
      end
   endfunction
   // state word layout: bit 9 always set, bit 5 inverted, bits 8 and 14 reserved zero
   function [31:0] sw_exp(input [12:0] s);
      begin
         sw_exp = {16'h0, s[9], 1'b0, s[11:10], s[12], s[8], 2'b10, s[7:6], ~s[5], s[4:0]};
      end
   endfunction
   task end_of_test;
      begin
         if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   initial begin
      #50000;
      err_count = err_count + 1;
      end_of_test;
   end
   initial begin
      tick(20);
      srst = 1'b0;
      acc(0, 16'h607f, 32'h0);
      chk("ceiling reset", rd, 32'h06400000);
      acc(0, 16'h60b8, 32'h0);
      chk("probe cfg reset", rd, 32'h0);
      acc(1, 16'h603f, 32'h5);
      chk("ro write answer", {30'h0, ae}, 32'h3);
      acc(0, 16'h1234, 32'h0);
      chk("unknown read answer", {30'h0, ae}, 32'h3);
      for (i = 0; i < 8; i = i + 1) begin
         v = rnd();
         st = v[12:0];
         code = v[27:16];
         position_target = rnd();
         software_limit = rnd();
         user_position = rnd();
         position_factor = rnd();
         err_ev = 1'b1;
         tick(1);
         err_ev = 1'b0;
         tick(1);
         chk("pulse position", pulse_position, user_position * position_factor);
         chk("target", effective_target, st[12] ? software_limit : position_target);
         acc(0, 16'h6041, 32'h0);
         chk("state word", rd, sw_exp(st));
         acc(0, 16'h6064, 32'h0);
         chk("actual position", rd, user_position);
         acc(0, 16'h603f, 32'h0);
         chk("error code", rd, {20'h0, code});
      end
      for (i = 0; i < 15; i = i + 1) begin
         c = rnd() & 32'hffff;
         acc(1, 16'h607f, c);
         acc(0, 16'h607f, 32'h0);
         chk("ceiling", rd, c);
         v = rnd();
         op_mode = mode_tab[8 * (i % 5) +: 8];
         speed_request = {{15{v[16]}}, v[16:0]};
         tick(2);
         v = clamp(op_mode, speed_request, c);
         chk("speed", speed_command, v);
         chk("limited", {31'h0, speed_limited}, {31'h0, v != speed_request});
      end
      user_position = 32'h11;
      acc(1, 16'h60b8, 32'h0011);
      tick(3);
      p1 = 1'b1;
      tick(4);
      chk("p1 rise", p1r, 32'h11);
      user_position = 32'h22;
      p1 = 1'b0;
      tick(4);
      p1 = 1'b1;
      tick(4);
      chk("p1 single", p1r, 32'h11);
      chk("flags single", {28'h0, probe_latched}, 32'h1);
      acc(1, 16'h60b8, 32'h0);
      // flags clear one edge after the disable lands, the output register adds one more
      tick(2);
      chk("flags off", {28'h0, probe_latched}, 32'h0);
      acc(1, 16'h60b8, 32'h0033);
      tick(3);
      for (i = 0; i < 4; i = i + 1) begin
         v = rnd();
         user_position = v;
         p1 = ~p1;
         tick(4);
         chk("p1 continuous", p1 ? p1r : p1f, v);
      end
      chk("flags both", {28'h0, probe_latched}, 32'h3);
      acc(1, 16'h60b8, 32'h3700);
      tick(3);
      user_position = 32'h33;
      enc_idx = 1'b1;
      tick(4);
      chk("index rise", {28'h0, probe_latched}, 32'h0);
      enc_idx = 1'b0;
      tick(4);
      chk("index fall", p2f, 32'h33);
      abs_enc = 1'b1;
      turn = 24'h0;
      tick(4);
      user_position = 32'h44;
      turn = 24'h5;
      tick(4);
      chk("abs index fall", p2f, 32'h44);
      acc(1, 16'h60b8, 32'h1100);
      tick(3);
      user_position = 32'h55;
      p2 = 1'b1;
      tick(4);
      chk("p2 rise", p2r, 32'h55);
      chk("flags two", {28'h0, probe_latched}, 32'hc);
      // mid-run reset must bring back the default ceiling and drop every flag
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      chk("flags reset", {28'h0, probe_latched}, 32'h0);
      acc(0, 16'h607f, 32'h0);
      chk("ceiling rerun", rd, 32'h06400000);
      end_of_test;
   end
endmodule // sod_core_test
bind sod_core sod_core_checker u_sod_core_checker (.*);
